/* logic/prox_irq_pkg.sv */
// Package with register map, field layout and reset values of the result/threshold interrupt block
`default_nettype none
package prox_irq_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_PROX_UPPER  = 8'h87;
  localparam logic [7:0] ADDR_PROX_LOWER  = 8'h88;
  localparam logic [7:0] ADDR_INT_CTRL    = 8'h89;
  localparam logic [7:0] ADDR_LOW_UPPER   = 8'h8A;
  localparam logic [7:0] ADDR_LOW_LOWER   = 8'h8B;
  localparam logic [7:0] ADDR_HIGH_UPPER  = 8'h8C;
  localparam logic [7:0] ADDR_HIGH_LOWER  = 8'h8D;
  localparam logic [7:0] ADDR_INT_STATUS  = 8'h8E;

  // Interrupt control fields
  localparam int         CTRL_THR_SEL_BIT  = 0;
  localparam int         CTRL_THR_EN_BIT   = 1;
  localparam int         CTRL_ALS_RDY_BIT  = 2;
  localparam int         CTRL_PROX_RDY_BIT = 3;
  localparam int         CTRL_PERSIST_LSB  = 5;
  localparam int         CTRL_PERSIST_W    = 3;
  localparam logic [7:0] CTRL_WRITE_MASK   = 8'hEF;

  // Interrupt status fields
  localparam int         STAT_HIGH_BIT     = 0;
  localparam int         STAT_LOW_BIT      = 1;
  localparam int         STAT_ALS_BIT      = 2;
  localparam int         STAT_PROX_BIT     = 3;
  localparam int         STAT_W            = 4;

  // Reset values
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [15:0] LOW_THR_RESET    = 16'h0000;
  localparam logic [15:0] HIGH_THR_RESET   = 16'hFFFF;
  localparam logic [15:0] RESULT_RESET     = 16'h0000;
  localparam logic [7:0]  RDATA_RESET      = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA    = 8'h00;
  localparam logic [7:0]  COUNT_ONE        = 8'h01;

  // Consecutive samples needed for a persistence code: 1, 2, 4 ... 128
  function automatic logic [7:0] persist_need(input logic [CTRL_PERSIST_W-1:0] sel);
    persist_need = COUNT_ONE << sel;
  endfunction : persist_need

endpackage : prox_irq_pkg
`default_nettype wire

/* logic/sticky_flags.sv */
// Sticky status flags with write-one-to-clear, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module sticky_flags #(
  parameter int W = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output var  logic [W-1:0] flags_o,
  output var  logic [W-1:0] flags_next_o
);
  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  // Clear by written ones, a same-cycle set still lands
  always_comb
  begin
    flags_next = (flags_reg & ~clr_i) | set_i;
  end

  // Flag storage
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      flags_reg <= '0;
    else
      flags_reg <= flags_next;
  end

  assign flags_o      = flags_reg;
  assign flags_next_o = flags_next;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_set_wins:  assert property (|set_i |=> ((flags_reg & $past(set_i)) == $past(set_i)))
    else $error("set flag lost");
  a_hold_flag: assert property (flags_reg != '0 && clr_i == '0 |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("flag dropped without clear");
endmodule : sticky_flags
`default_nettype wire

/* logic/persist_filter.sv */
// Threshold comparison with consecutive-sample persistence filter
`timescale 1ns/100ps
`default_nettype none
module persist_filter
  import prox_irq_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      valid_i,
  input  wire logic [DW-1:0]             sample_i,
  input  wire logic [DW-1:0]             low_thr_i,
  input  wire logic [DW-1:0]             high_thr_i,
  input  wire logic [CTRL_PERSIST_W-1:0] persist_sel_i,
  input  wire logic                      enable_i,
  output var  logic                      low_evt_o,
  output var  logic                      high_evt_o
);
  logic [7:0] run_reg;
  logic [7:0] run_next;
  logic       above;
  logic       below;
  logic       fire;

  // Unsigned window test and run counting
  always_comb
  begin
    above    = sample_i > high_thr_i;
    below    = sample_i < low_thr_i;
    fire     = valid_i && enable_i && (above || below) && (run_reg + COUNT_ONE >= persist_need(persist_sel_i));
    run_next = run_reg;
    if (!enable_i)
      run_next = '0;
    else if (valid_i)
    begin
      if (!(above || below) || fire)
        run_next = '0;
      else
        run_next = run_reg + COUNT_ONE;
    end
    low_evt_o  = fire && below;
    high_evt_o = fire && above;
  end

  // Run counter
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      run_reg <= '0;
    else
      run_reg <= run_next;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_persist_count: assert property (low_evt_o || high_evt_o |-> run_reg + COUNT_ONE >= persist_need(persist_sel_i))
    else $error("threshold event before run complete");
  a_high_cmp:      assert property (high_evt_o |-> sample_i > high_thr_i && valid_i)
    else $error("high event without high crossing");
  a_low_cmp:       assert property (low_evt_o |-> sample_i < low_thr_i && valid_i)
    else $error("low event without low crossing");
endmodule : persist_filter
`default_nettype wire

/* logic/prox_result_threshold_irq.sv */
// Proximity result, threshold and interrupt register block with active-low interrupt pin
`timescale 1ns/100ps
`default_nettype none
module prox_result_threshold_irq (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Measurement results from the converters
  input  wire logic [15:0] prox_result_i,
  input  wire logic        prox_valid_i,
  input  wire logic [15:0] als_result_i,
  input  wire logic        als_valid_i,
  // Byte register port behind the serial slave
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output var  logic [7:0]  reg_rdata_o,
  // Interrupt pad, low while any flag is set
  output var  logic        int_n_o
);
  import prox_irq_pkg::*;

  // Stored result, configuration and thresholds
  logic [15:0]        prox_reg;
  logic [15:0]        prox_next;
  logic [7:0]         ctrl_reg;
  logic [7:0]         ctrl_next;
  logic [15:0]        low_thr_reg;
  logic [15:0]        low_thr_next;
  logic [15:0]        high_thr_reg;
  logic [15:0]        high_thr_next;

  // Read port and interrupt pad
  logic [7:0]         rdata_reg;
  logic [7:0]         rdata_next;
  logic               int_n_reg;
  logic               int_n_next;

  // Status flag sources, clears and state
  logic [STAT_W-1:0]  stat_set;
  logic [STAT_W-1:0]  stat_clr;
  logic [STAT_W-1:0]  status;
  logic [STAT_W-1:0]  status_next;

  // Comparator input from the selected channel
  logic               cmp_valid;
  logic [15:0]        cmp_sample;
  logic               low_evt;
  logic               high_evt;

  // Result capture and host writes to control and thresholds
  always_comb
  begin
    prox_next     = prox_reg;
    ctrl_next     = ctrl_reg;
    low_thr_next  = low_thr_reg;
    high_thr_next = high_thr_reg;
    // Both bytes take a new result together; a host reading them one at a time
    // may pair an upper byte with the lower byte of a later result
    if (prox_valid_i)
      prox_next = prox_result_i;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        ADDR_INT_CTRL:   ctrl_next           = reg_wdata_i & CTRL_WRITE_MASK;
        ADDR_LOW_UPPER:  low_thr_next[15:8]  = reg_wdata_i;
        ADDR_LOW_LOWER:  low_thr_next[7:0]   = reg_wdata_i;
        ADDR_HIGH_UPPER: high_thr_next[15:8] = reg_wdata_i;
        ADDR_HIGH_LOWER: high_thr_next[7:0]  = reg_wdata_i;
        default:         ; // Result bytes and unmapped addresses ignore writes
      endcase
    end
  end

  // Configuration and result storage
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      prox_reg     <= RESULT_RESET;
      ctrl_reg     <= CTRL_RESET;
      low_thr_reg  <= LOW_THR_RESET;
      high_thr_reg <= HIGH_THR_RESET;
    end
    else
    begin
      prox_reg     <= prox_next;
      ctrl_reg     <= ctrl_next;
      low_thr_reg  <= low_thr_next;
      high_thr_reg <= high_thr_next;
    end
  end

  // Threshold source selection; pulses of the channel that is not selected
  // never reach the filter, so they neither count nor break a run
  always_comb
  begin
    if (ctrl_reg[CTRL_THR_SEL_BIT])
    begin
      cmp_valid  = als_valid_i;
      cmp_sample = als_result_i;
    end
    else
    begin
      cmp_valid  = prox_valid_i;
      cmp_sample = prox_result_i;
    end
  end

  // Window comparator with the consecutive-sample filter
  persist_filter #(
    .DW            (16)
  ) u_persist (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .valid_i       (cmp_valid),
    .sample_i      (cmp_sample),
    .low_thr_i     (low_thr_reg),
    .high_thr_i    (high_thr_reg),
    .persist_sel_i (ctrl_reg[CTRL_PERSIST_LSB +: CTRL_PERSIST_W]),
    .enable_i      (ctrl_reg[CTRL_THR_EN_BIT]),
    .low_evt_o     (low_evt),
    .high_evt_o    (high_evt)
  );

  // Interrupt sources and write-one clears of the status register
  always_comb
  begin
    stat_set                = '0;
    stat_set[STAT_PROX_BIT] = prox_valid_i && ctrl_reg[CTRL_PROX_RDY_BIT];
    stat_set[STAT_ALS_BIT]  = als_valid_i && ctrl_reg[CTRL_ALS_RDY_BIT];
    stat_set[STAT_LOW_BIT]  = low_evt;
    stat_set[STAT_HIGH_BIT] = high_evt;
    stat_clr                = '0;
    if (reg_wr_i && reg_addr_i == ADDR_INT_STATUS)
      stat_clr = reg_wdata_i[STAT_W-1:0];
  end

  // Status flags; a same-cycle set beats a write-one clear
  sticky_flags #(
    .W            (STAT_W)
  ) u_status (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .set_i        (stat_set),
    .clr_i        (stat_clr),
    .flags_o      (status),
    .flags_next_o (status_next)
  );

  // Byte lane of a 16-bit word as the byte register port shows it
  function automatic logic [7:0] byte_of(input logic [15:0] word, input logic upper);
    byte_of = upper ? word[15:8] : word[7:0];
  endfunction : byte_of

  // Read data mux; the last read byte stays on the port until the next read
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        ADDR_PROX_UPPER: rdata_next = byte_of(prox_reg, 1'b1);
        ADDR_PROX_LOWER: rdata_next = byte_of(prox_reg, 1'b0);
        ADDR_INT_CTRL:   rdata_next = ctrl_reg;
        ADDR_LOW_UPPER:  rdata_next = byte_of(low_thr_reg, 1'b1);
        ADDR_LOW_LOWER:  rdata_next = byte_of(low_thr_reg, 1'b0);
        ADDR_HIGH_UPPER: rdata_next = byte_of(high_thr_reg, 1'b1);
        ADDR_HIGH_LOWER: rdata_next = byte_of(high_thr_reg, 1'b0);
        ADDR_INT_STATUS: rdata_next = {{(8-STAT_W){1'b0}}, status};
        default:         rdata_next = UNMAPPED_DATA;                // Unmapped reads return zero
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rdata_reg <= RDATA_RESET;
    else
      rdata_reg <= rdata_next;
  end

  // Pad level follows the flags as they will be after this edge, so a clear
  // releases the pad on the same edge that drops the last flag
  always_comb
  begin
    int_n_next = ~(|status_next);
  end

  // Interrupt pad register, released (high) out of reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      int_n_reg <= 1'b1;
    else
      int_n_reg <= int_n_next;
  end

  // Both outputs leave straight from their flip-flops
  assign reg_rdata_o = rdata_reg;
  assign int_n_o     = int_n_reg;

  // Checks and covers; all of them sleep while reset is held
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_prox_capture: assert property (prox_valid_i |=> prox_reg == $past(prox_result_i))
    else $error("proximity result not captured");
  a_prox_read_hi: assert property (reg_rd_i && reg_addr_i == ADDR_PROX_UPPER
                                   |=> reg_rdata_o == $past(prox_reg[15:8]))
    else $error("upper result byte read wrong");
  a_result_ro:    assert property (reg_wr_i && !prox_valid_i
                                   && (reg_addr_i == ADDR_PROX_UPPER || reg_addr_i == ADDR_PROX_LOWER)
                                   |=> $stable(prox_reg))
    else $error("result byte changed by host write");
  a_thr_disabled: assert property (!ctrl_reg[CTRL_THR_EN_BIT] |-> !low_evt && !high_evt)
    else $error("threshold event while disabled");
  a_source_sel:   assert property (ctrl_reg[CTRL_THR_SEL_BIT] && !als_valid_i |-> !low_evt && !high_evt)
    else $error("threshold event from unselected channel");
  a_prox_ready:   assert property (prox_valid_i && ctrl_reg[CTRL_PROX_RDY_BIT] |=> status[STAT_PROX_BIT])
    else $error("proximity ready flag not set");
  a_als_quiet:    assert property (als_valid_i && !ctrl_reg[CTRL_ALS_RDY_BIT] && !status[STAT_ALS_BIT]
                                   |=> !status[STAT_ALS_BIT])
    else $error("ambient ready flag set while disabled");
  a_low_write:    assert property (reg_wr_i && reg_addr_i == ADDR_LOW_UPPER
                                   |=> low_thr_reg[15:8] == $past(reg_wdata_i))
    else $error("low threshold upper byte not written");
  a_high_write:   assert property (reg_wr_i && reg_addr_i == ADDR_HIGH_UPPER
                                   |=> high_thr_reg[15:8] == $past(reg_wdata_i))
    else $error("high threshold upper byte not written");
  a_high_store:   assert property (reg_wr_i && reg_addr_i == ADDR_HIGH_LOWER
                                   |=> high_thr_reg[7:0] == $past(reg_wdata_i))
    else $error("high threshold lower byte not stored");
  a_high_flag:    assert property (high_evt |=> status[STAT_HIGH_BIT])
    else $error("high crossing flag not set");
  a_w1c_clear:    assert property (reg_wr_i && reg_addr_i == ADDR_INT_STATUS && reg_wdata_i[STAT_LOW_BIT]
                                   && !low_evt |=> !status[STAT_LOW_BIT])
    else $error("write one did not clear flag");
  a_int_pin:      assert property (int_n_o == !(|status))
    else $error("interrupt pad disagrees with flags");

  // Register port: writes land, reads show the stored bytes
  a_prox_read_lo: assert property (reg_rd_i && reg_addr_i == ADDR_PROX_LOWER
                                   |=> reg_rdata_o == $past(prox_reg[7:0]))
    else $error("lower result byte read wrong");
  a_ctrl_write:   assert property (reg_wr_i && reg_addr_i == ADDR_INT_CTRL
                                   |=> ctrl_reg == ($past(reg_wdata_i) & CTRL_WRITE_MASK))
    else $error("control byte not stored");
  a_ctrl_read:    assert property (reg_rd_i && reg_addr_i == ADDR_INT_CTRL
                                   |=> reg_rdata_o == $past(ctrl_reg))
    else $error("control byte read wrong");
  a_low_lower:    assert property (reg_wr_i && reg_addr_i == ADDR_LOW_LOWER
                                   |=> low_thr_reg[7:0] == $past(reg_wdata_i))
    else $error("low threshold lower byte not written");
  a_low_read:     assert property (reg_rd_i && reg_addr_i == ADDR_LOW_LOWER
                                   |=> reg_rdata_o == $past(low_thr_reg[7:0]))
    else $error("low threshold lower byte read wrong");
  a_high_read:    assert property (reg_rd_i && reg_addr_i == ADDR_HIGH_UPPER
                                   |=> reg_rdata_o == $past(high_thr_reg[15:8]))
    else $error("high threshold upper byte read wrong");
  a_high_rd_lo:   assert property (reg_rd_i && reg_addr_i == ADDR_HIGH_LOWER
                                   |=> reg_rdata_o == $past(high_thr_reg[7:0]))
    else $error("high threshold lower byte read wrong");
  a_status_read:  assert property (reg_rd_i && reg_addr_i == ADDR_INT_STATUS
                                   |=> reg_rdata_o == {{(8-STAT_W){1'b0}}, $past(status)})
    else $error("status byte read wrong");
  a_thr_hold:     assert property (!reg_wr_i
                                   |=> $stable(low_thr_reg) && $stable(high_thr_reg))
    else $error("threshold changed without a write");

  // Flag sources, source selection and pad
  a_low_flag:     assert property (low_evt |=> status[STAT_LOW_BIT])
    else $error("low crossing flag not set");
  a_als_ready:    assert property (als_valid_i && ctrl_reg[CTRL_ALS_RDY_BIT]
                                   |=> status[STAT_ALS_BIT])
    else $error("ambient ready flag not set");
  a_ready_pad:    assert property (prox_valid_i && ctrl_reg[CTRL_PROX_RDY_BIT]
                                   |=> !int_n_o)
    else $error("pad not low after ready flag");
  a_prox_source:  assert property (!ctrl_reg[CTRL_THR_SEL_BIT] && ctrl_reg[CTRL_THR_EN_BIT]
                                   && ctrl_reg[CTRL_PERSIST_LSB +: CTRL_PERSIST_W] == '0
                                   && prox_valid_i && prox_result_i > high_thr_reg |-> high_evt)
    else $error("proximity crossing missed");
  a_als_source:   assert property (ctrl_reg[CTRL_THR_SEL_BIT] && ctrl_reg[CTRL_THR_EN_BIT]
                                   && ctrl_reg[CTRL_PERSIST_LSB +: CTRL_PERSIST_W] == '0
                                   && als_valid_i && als_result_i > high_thr_reg |-> high_evt)
    else $error("ambient crossing missed");

  // Write-one clears and disabled ready sources
  a_w1c_high:     assert property (reg_wr_i && reg_addr_i == ADDR_INT_STATUS && reg_wdata_i[STAT_HIGH_BIT]
                                   && !high_evt |=> !status[STAT_HIGH_BIT])
    else $error("write one did not clear high flag");
  a_w1c_als:      assert property (reg_wr_i && reg_addr_i == ADDR_INT_STATUS && reg_wdata_i[STAT_ALS_BIT]
                                   && !(als_valid_i && ctrl_reg[CTRL_ALS_RDY_BIT]) |=> !status[STAT_ALS_BIT])
    else $error("write one did not clear ambient flag");
  a_prox_quiet:   assert property (prox_valid_i && !ctrl_reg[CTRL_PROX_RDY_BIT] && !status[STAT_PROX_BIT]
                                   |=> !status[STAT_PROX_BIT])
    else $error("proximity ready flag set while disabled");

  // Main scenarios
  c_persist_fire: cover property (high_evt && ctrl_reg[CTRL_PERSIST_LSB +: CTRL_PERSIST_W] != '0);
  c_als_low:      cover property (low_evt && ctrl_reg[CTRL_THR_SEL_BIT]);
  c_pin_release:  cover property (!int_n_o ##1 int_n_o);
  c_set_and_clr:  cover property (stat_set != '0 && (stat_set & stat_clr) != '0);
  c_low_prox:     cover property (low_evt && !ctrl_reg[CTRL_THR_SEL_BIT]);
endmodule : prox_result_threshold_irq
`default_nettype wire

/* verification/host_port_model.sv */
// Host side model that drives byte register cycles and notes expected read data
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
  input  wire logic       clk_sys_i,
  output var  logic [7:0] reg_addr_o,
  output var  logic       reg_wr_o,
  output var  logic [7:0] reg_wdata_o,
  output var  logic       reg_rd_o
);
  logic [7:0] exp_q[$];

  // Bus idle at time zero
  initial
  begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  // Write one byte; strobe stays up so calls may run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    reg_rd_o    = 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask : wr

  // Read one byte and note what must come back
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr_o = a;
    reg_wr_o   = 1'b0;
    reg_rd_o   = 1'b1;
    @(posedge clk_sys_i);
    #1;
  endtask : rd

  // Write ones to clear status flags
  task automatic clr(input logic [7:0] m);
    wr(8'h8E, m);
  endtask : clr

  // Release the bus; strobes drop low, address and data show the inverse of their last value
  task automatic idle();
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
    @(posedge clk_sys_i);
    #1;
  endtask : idle
endmodule : host_port_model
`default_nettype wire

/* verification/prox_result_threshold_irq_test.sv */
// Self-checking bench for the result, threshold and interrupt register block
`timescale 1ns/100ps
`default_nettype none
module prox_result_threshold_irq_test;
  import prox_irq_pkg::*;
  logic        clk_sys     = 1'b0;
  logic        rst_n       = 1'b0;
  logic        prox_valid  = 1'b0;
  logic        als_valid   = 1'b0;
  logic [15:0] prox_result = 16'h0000;
  logic [15:0] als_result  = 16'h0000;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        int_n;
  logic        rd_q        = 1'b0;
  int          error_cnt       = 0;
  int          samples_checked = 0;
  int          cycles      = 0;
  logic [15:0] rv;
  logic [7:0]  b[4];
  logic [7:0]  ra[9] = '{8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h80};
  logic [7:0]  rx[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
  logic [15:0] tv[7] = '{16'h0300, 16'h0050, 16'h0150, 16'h0200, 16'h0100, 16'h0201, 16'h00FF};
  logic [7:0]  te[7] = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02};

  always #4 clk_sys = ~clk_sys;

  prox_result_threshold_irq prox_result_threshold_irq_i (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .prox_result_i(prox_result), .prox_valid_i(prox_valid),
    .als_result_i(als_result), .als_valid_i(als_valid), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .int_n_o(int_n));

  host_port_model host_port_model_i (
    .clk_sys_i(clk_sys), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
    .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd));

  // Verdict and end of run
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Compare one read byte
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected read data at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_byte

  // Compare the interrupt pad level
  task automatic check_int(input logic exp);
    samples_checked++;
    if (int_n !== exp)
    begin
      error_cnt++;
      $display("unexpected interrupt pad at %0t: got %0h expected %0h", $time, int_n, exp);
    end
  endtask : check_int

  // One measurement pulse; the bus is released first so no strobe repeats
  task automatic meas(input logic als, input logic [15:0] v);
    host_port_model_i.idle();
    prox_result = v;
    als_result  = v;
    prox_valid  = ~als;
    als_valid   = als;
    @(posedge clk_sys);
    #1;
    prox_valid  = 1'b0;
    als_valid   = 1'b0;
    prox_result = ~v;
    als_result  = ~v;
    @(posedge clk_sys);
    #1;
  endtask : meas

  // Read status, check pad, clear all flags, check pad released
  task automatic st(input logic [7:0] e, input logic ei);
    host_port_model_i.rd(ADDR_INT_STATUS, e);
    check_int(ei);
    host_port_model_i.clr(8'hFF);
    host_port_model_i.idle();
    check_int(1'b1);
  endtask : st

  // Read data lands one cycle after each read strobe; take the oldest note
  always @(posedge clk_sys) rd_q <= reg_rd & rst_n;
  always @(negedge clk_sys)
    if (rd_q)
      check_byte(reg_rdata, host_port_model_i.exp_q.pop_front());

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h6201));
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    @(posedge clk_sys);
    #1;
    foreach (ra[i]) host_port_model_i.rd(ra[i], rx[i]);
    check_int(1'b1);
    foreach (b[i])
    begin
      b[i] = 8'($urandom);
      host_port_model_i.wr(ADDR_LOW_UPPER + 8'(i), b[i]);
    end
    foreach (b[i]) host_port_model_i.rd(ADDR_LOW_UPPER + 8'(i), b[i]);
    host_port_model_i.wr(ADDR_INT_CTRL, 8'hFF);
    host_port_model_i.rd(ADDR_INT_CTRL, 8'hEF);
    host_port_model_i.wr(ADDR_INT_CTRL, 8'h00);
    rv = 16'($urandom);
    meas(1'b0, rv);
    host_port_model_i.wr(ADDR_PROX_UPPER, ~rv[15:8]);
    host_port_model_i.wr(ADDR_PROX_LOWER, ~rv[7:0]);
    host_port_model_i.rd(ADDR_PROX_UPPER, rv[15:8]);
    host_port_model_i.rd(ADDR_PROX_LOWER, rv[7:0]);
    meas(1'b1, rv);
    st(8'h00, 1'b1);
    host_port_model_i.wr(ADDR_INT_CTRL, 8'h0C);
    meas(1'b0, rv);
    meas(1'b1, rv);
    host_port_model_i.clr(8'h08);
    st(8'h04, 1'b0);
    host_port_model_i.wr(ADDR_LOW_UPPER, 8'h01);
    host_port_model_i.wr(ADDR_LOW_LOWER, 8'h00);
    host_port_model_i.wr(ADDR_HIGH_UPPER, 8'h02);
    host_port_model_i.wr(ADDR_HIGH_LOWER, 8'h00);
    host_port_model_i.wr(ADDR_INT_CTRL, 8'h02);
    foreach (tv[i])
    begin
      meas(1'b0, tv[i]);
      st(te[i], te[i] == 8'h00);
    end
    host_port_model_i.wr(ADDR_INT_CTRL, 8'h03);
    meas(1'b0, 16'h0300);
    st(8'h00, 1'b1);
    meas(1'b1, 16'h0300);
    st(8'h01, 1'b0);
    host_port_model_i.wr(ADDR_INT_CTRL, 8'h00);
    meas(1'b0, 16'h0300);
    st(8'h00, 1'b1);
    host_port_model_i.wr(ADDR_INT_CTRL, 8'h42);
    repeat (3) meas(1'b0, 16'h0300);
    meas(1'b0, 16'h0150);
    repeat (3) meas(1'b0, 16'h0300);
    st(8'h00, 1'b1);
    meas(1'b0, 16'h0300);
    st(8'h01, 1'b0);
    // Reset in mid-run with a flag set: pad releases, registers return to reset values
    host_port_model_i.wr(ADDR_INT_CTRL, 8'h08);
    meas(1'b0, 16'h0300);
    check_int(1'b0);
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    @(posedge clk_sys);
    #1;
    check_int(1'b1);
    foreach (ra[i]) host_port_model_i.rd(ra[i], rx[i]);
    host_port_model_i.idle();
    complete_run();
  end
endmodule : prox_result_threshold_irq_test
`default_nettype wire
